/* File: tpo_top.sv */
// Operation
// R1 - Sixteen outputs form four 4-bit groups
// R2 - Pattern output enabled per individual bit
// R3 - Each group picks one of four matches
// R4 - Non-overlap mode delays rising bits by gap
// R5 - Selected matches also raise DMA requests
// R6 - Pattern-owned port data bits ignore writes
// R7 - Decode only A27-A24 and A8-A0
// R8 - Low next-data address split by shared trigger
// R9 - High next-data address split by shared trigger
// R10 - Mode resets F0, trigger select FF
// R11 - Match copies next data to port data
// R12 - Unused next-data bits read one, ignore writes
// R13 - Software assigns pattern pins in function control
// R14 - Next data cleared only by reset
// R15 - Only enabled bits update on trigger
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tpo_regs.svh"
module tpo_top
	import tpo_pkg::*;
#(
	parameter int NUM_GROUPS = 4,
	parameter int GAP_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire tpo_apb_req_t apb_req_in,
	output tpo_apb_rsp_t apb_rsp_out,
	input wire logic [3:0] cmp_match_in,
	output logic [15:0] pattern_out_pins_out,
	output logic [15:0] pattern_oe_out,
	output logic [31:0] port_b_func_out,
	output logic [3:0] dma_req_out
);

	generate
		if (NUM_GROUPS != 4) begin : g_bad_groups
			$error("tpo_top: the register map serves exactly four groups");
		end
		if (GAP_W != 8) begin : g_bad_gap
			$error("tpo_top: the gap register is eight bits wide");
		end
		if (NUM_GROUPS * `TPO_SEL_W != 8) begin : g_bad_sel
			$error("tpo_top: trigger select fields must fill one byte");
		end
		if (`TPO_MODE_NOVL_W != NUM_GROUPS) begin : g_bad_mode
			$error("tpo_top: one non-overlap mode bit per group");
		end
	endgenerate

	// Software-visible registers
	logic [15:0] port_b_output_data;
	logic [15:0] port_b_function_ctrl_high;
	logic [15:0] port_b_function_ctrl_low;
	logic [7:0] pattern_output_mode;
	logic [7:0] pattern_trigger_select;
	logic [7:0] next_data_enable_high;
	logic [7:0] next_data_enable_low;
	logic [7:0] next_data_high;
	logic [7:0] next_data_low;
	logic [7:0] nonoverlap_gap;

	// Per-group trigger and load nets
	logic [15:0] nden;
	logic [15:0] nd;
	logic [3:0] trig;
	logic [3:0] grp_load;
	logic [15:0] grp_data;
	logic [3:0] used_ch;
	logic [15:0] next_port_b_output_data;
	logic same_low;
	logic same_high;

	// Bus decode and response
	logic [27:0] idx;
	logic wr;
	logic setup_rd;
	logic [31:0] rd_data;
	logic rd_err;
	logic [31:0] prdata_q;
	logic pslverr_q;

	logic hit_port;
	logic hit_fhi;
	logic hit_flo;
	logic hit_mode;
	logic hit_sel;
	logic hit_enhi;
	logic hit_enlo;
	logic hit_ndhi;
	logic hit_ndlo;
	logic hit_ndg2;
	logic hit_ndg0;
	logic hit_gap;

	// Compares only the decoded bits of the register index
	function automatic logic hit(input logic [27:0] a, input logic [27:0] c);
		hit = (a[`TPO_DEC_HI_MSB:`TPO_DEC_HI_LSB] == c[`TPO_DEC_HI_MSB:`TPO_DEC_HI_LSB])
			&& (a[`TPO_DEC_LO_MSB:0] == c[`TPO_DEC_LO_MSB:0]);
	endfunction : hit

	// Bits 25..11 of the byte address are don't-care, so the map repeats
	assign idx = apb_req_in.paddr[29:2];
	assign hit_port = hit(idx, `TPO_IDX_PORT_DATA); // R7
	assign hit_fhi = hit(idx, `TPO_IDX_FUNC_HIGH);
	assign hit_flo = hit(idx, `TPO_IDX_FUNC_LOW);
	assign hit_mode = hit(idx, `TPO_IDX_MODE);
	assign hit_sel = hit(idx, `TPO_IDX_TRIG_SEL);
	assign hit_enhi = hit(idx, `TPO_IDX_NDEN_HIGH);
	assign hit_enlo = hit(idx, `TPO_IDX_NDEN_LOW);
	assign hit_ndhi = hit(idx, `TPO_IDX_ND_HIGH);
	assign hit_ndlo = hit(idx, `TPO_IDX_ND_LOW);
	assign hit_ndg2 = hit(idx, `TPO_IDX_ND_G2);
	assign hit_ndg0 = hit(idx, `TPO_IDX_ND_G0);
	assign hit_gap = hit(idx, `TPO_IDX_GAP);

	assign wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
	assign setup_rd = apb_req_in.psel && !apb_req_in.penable;

	assign nden = {next_data_enable_high, next_data_enable_low};
	assign nd = {next_data_high, next_data_low};
	// Equal select fields mean the pair shares one trigger
	assign same_low = pattern_trigger_select[1:0] == pattern_trigger_select[3:2];
	assign same_high = pattern_trigger_select[5:4] == pattern_trigger_select[7:6];

	// Reserved next-data nibbles read as ones however the pairs are split
	always_comb begin
		rd_err = 1'b0;
		rd_data = 32'h0000_0000;
		if (hit_port) begin
			rd_data[15:0] = port_b_output_data; // R6
		end else if (hit_fhi) begin
			rd_data[15:0] = port_b_function_ctrl_high;
		end else if (hit_flo) begin
			rd_data[15:0] = port_b_function_ctrl_low;
		end else if (hit_mode) begin
			rd_data[7:0] = pattern_output_mode;
		end else if (hit_sel) begin
			rd_data[7:0] = pattern_trigger_select;
		end else if (hit_enhi) begin
			rd_data[7:0] = next_data_enable_high;
		end else if (hit_enlo) begin
			rd_data[7:0] = next_data_enable_low;
		end else if (hit_ndhi) begin
			rd_data[7:0] = same_high ? next_data_high
				: {next_data_high[7:4], `TPO_RSVD_NIB}; // R9
		end else if (hit_ndlo) begin
			rd_data[7:0] = same_low ? next_data_low
				: {next_data_low[7:4], `TPO_RSVD_NIB}; // R8
		end else if (hit_ndg2) begin
			rd_data[7:0] = same_high ? `TPO_RSVD_BYTE
				: {`TPO_RSVD_NIB, next_data_high[3:0]}; // R12
		end else if (hit_ndg0) begin
			rd_data[7:0] = same_low ? `TPO_RSVD_BYTE
				: {`TPO_RSVD_NIB, next_data_low[3:0]}; // R12
		end else if (hit_gap) begin
			rd_data[7:0] = nonoverlap_gap;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Read data is captured in the setup cycle so prdata comes from a flop
	// A load on that same edge is not seen by the read; the next read has it
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_rd) begin
			prdata_q <= apb_req_in.pwrite ? 32'h0000_0000 : rd_data;
			pslverr_q <= rd_err;
		end
	end

	assign apb_rsp_out.prdata = prdata_q;
	assign apb_rsp_out.pslverr = pslverr_q && apb_req_in.psel && apb_req_in.penable;
	// Zero wait states: every access cycle completes at once
	assign apb_rsp_out.pready = apb_req_in.psel && apb_req_in.penable;

	// Function control is only stored here; the pin mux sits outside
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port_b_function_ctrl_high <= `TPO_RST_FUNC;
			port_b_function_ctrl_low <= `TPO_RST_FUNC;
		end else if (wr) begin
			if (hit_fhi && apb_req_in.pstrb[0]) begin
				port_b_function_ctrl_high[7:0] <= apb_req_in.pwdata[7:0];
			end
			if (hit_fhi && apb_req_in.pstrb[1]) begin
				port_b_function_ctrl_high[15:8] <= apb_req_in.pwdata[15:8];
			end
			if (hit_flo && apb_req_in.pstrb[0]) begin
				port_b_function_ctrl_low[7:0] <= apb_req_in.pwdata[7:0];
			end
			if (hit_flo && apb_req_in.pstrb[1]) begin
				port_b_function_ctrl_low[15:8] <= apb_req_in.pwdata[15:8];
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pattern_output_mode <= `TPO_RST_MODE; // R10
			pattern_trigger_select <= `TPO_RST_TRIG_SEL; // R10
			nonoverlap_gap <= `TPO_RST_GAP;
		end else if (wr && apb_req_in.pstrb[0]) begin
			// Upper nibble is fixed so software always reads ones there
			if (hit_mode) begin
				pattern_output_mode <= {`TPO_MODE_FIXED,
					apb_req_in.pwdata[`TPO_MODE_NOVL_W-1:0]};
			end
			if (hit_sel) begin
				pattern_trigger_select <= apb_req_in.pwdata[7:0]; // R3
			end
			if (hit_gap) begin
				nonoverlap_gap <= apb_req_in.pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			next_data_enable_high <= `TPO_RST_NDEN; // R10
			next_data_enable_low <= `TPO_RST_NDEN; // R10
		end else if (wr && apb_req_in.pstrb[0]) begin
			// Enables double as pin output enables and as the write mask
			if (hit_enhi) begin
				next_data_enable_high <= apb_req_in.pwdata[7:0]; // R2
			end
			if (hit_enlo) begin
				next_data_enable_low <= apb_req_in.pwdata[7:0]; // R2
			end
		end
	end

	// Only the system reset clears next data; standby leaves it alone
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			next_data_high <= `TPO_RST_ND; // R14
			next_data_low <= `TPO_RST_ND; // R14
		end else if (wr && apb_req_in.pstrb[0]) begin
			if (hit_ndlo) begin
				if (same_low) begin
					next_data_low <= apb_req_in.pwdata[7:0]; // R8
				end else begin
					next_data_low[7:4] <= apb_req_in.pwdata[7:4]; // R12
				end
			end
			// A write to one split half leaves the other half alone
			if (hit_ndg0 && !same_low) begin
				next_data_low[3:0] <= apb_req_in.pwdata[3:0]; // R8
			end
			if (hit_ndhi) begin
				if (same_high) begin
					next_data_high <= apb_req_in.pwdata[7:0]; // R9
				end else begin
					next_data_high[7:4] <= apb_req_in.pwdata[7:4]; // R12
				end
			end
			if (hit_ndg2 && !same_high) begin
				next_data_high[3:0] <= apb_req_in.pwdata[3:0]; // R9
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
			logic [`TPO_SEL_W-1:0] sel;
			assign sel = pattern_trigger_select[g*`TPO_SEL_W +: `TPO_SEL_W];
			// Each group picks its own match, so the pairs can split freely
			assign trig[g] = cmp_match_in[sel]; // R3
			// Gap counts whole clock cycles; a gap of zero is a plain load
			tpo_group #(
				.GAP_W(GAP_W)
			) u_group (
				.clk_in(clk_in),
				.resetn_in(resetn_in),
				.trig_in(trig[g]), // R1
				.nonovl_in(pattern_output_mode[g]),
				.gap_in(nonoverlap_gap),
				.cur_in(port_b_output_data[g*4 +: 4]),
				.next_in(nd[g*4 +: 4]),
				.load_out(grp_load[g]),
				.data_out(grp_data[g*4 +: 4])
			);
		end
	endgenerate

	always_comb begin
		next_port_b_output_data = port_b_output_data;
		// Enabled bits belong to the trigger path, so software writes skip them
		if (wr && hit_port) begin
			for (int b = 0; b < 2; b++) begin
				if (apb_req_in.pstrb[b]) begin
					next_port_b_output_data[b*8 +: 8] =
						(port_b_output_data[b*8 +: 8] & nden[b*8 +: 8])
						| (apb_req_in.pwdata[b*8 +: 8] & ~nden[b*8 +: 8]); // R6
				end
			end
		end
		// A trigger load and a write in the same cycle both land: the load on enabled bits, the write on the rest
		for (int k = 0; k < NUM_GROUPS; k++) begin
			if (grp_load[k]) begin
				next_port_b_output_data[k*4 +: 4] =
					(next_port_b_output_data[k*4 +: 4] & ~nden[k*4 +: 4])
					| (grp_data[k*4 +: 4] & nden[k*4 +: 4]); // R15
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			port_b_output_data <= `TPO_RST_PORT_DATA;
		end else begin
			port_b_output_data <= next_port_b_output_data; // R11
		end
	end

	always_comb begin
		// A channel requests DMA only while some group listens to it
		used_ch = 4'h0;
		for (int k = 0; k < NUM_GROUPS; k++) begin
			used_ch[pattern_trigger_select[k*`TPO_SEL_W +: `TPO_SEL_W]] = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dma_req_out <= 4'h0;
		end else begin
			// Registered so a select write cannot glitch the request lines
			dma_req_out <= cmp_match_in & used_ch; // R5
		end
	end

	assign pattern_out_pins_out = port_b_output_data; // R11
	assign pattern_oe_out = nden; // R2
	// Pin muxing outside uses these; pattern pins need their function set
	assign port_b_func_out = {port_b_function_ctrl_high, port_b_function_ctrl_low}; // R13

endmodule : tpo_top
`default_nettype wire

/* File: tpo_regs.svh */
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH

// Register indices; the APB byte address is four times the index
`define TPO_IDX_PORT_DATA 28'h5ffffc2
`define TPO_IDX_FUNC_HIGH 28'h5ffffcc
`define TPO_IDX_FUNC_LOW 28'h5ffffce
`define TPO_IDX_MODE 28'h5fffff0
`define TPO_IDX_TRIG_SEL 28'h5fffff1
`define TPO_IDX_NDEN_HIGH 28'h5fffff2
`define TPO_IDX_NDEN_LOW 28'h5fffff3
`define TPO_IDX_ND_HIGH 28'h5fffff4
`define TPO_IDX_ND_LOW 28'h5fffff5
`define TPO_IDX_ND_G2 28'h5fffff6
`define TPO_IDX_ND_G0 28'h5fffff7
`define TPO_IDX_GAP 28'h5fffff8

// Decoded index fields: upper nibble and low nine bits
`define TPO_DEC_HI_MSB 27
`define TPO_DEC_HI_LSB 24
`define TPO_DEC_LO_MSB 8

// Reset values
`define TPO_RST_PORT_DATA 16'h0000
`define TPO_RST_FUNC 16'h0000
`define TPO_RST_MODE 8'hf0
`define TPO_RST_TRIG_SEL 8'hff
`define TPO_RST_NDEN 8'h00
`define TPO_RST_ND 8'h00
`define TPO_RST_GAP 8'h00

// Field layout
`define TPO_MODE_NOVL_W 4
`define TPO_MODE_FIXED 4'hf
`define TPO_SEL_W 2
`define TPO_RSVD_NIB 4'hf
`define TPO_RSVD_BYTE 8'hff

`endif

/* File: tpo_pkg.sv */
package tpo_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} tpo_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tpo_apb_rsp_t;

	typedef enum logic [1:0] {
		TPO_ST_IDLE = 2'b01,
		TPO_ST_GAP = 2'b10
	} tpo_grp_state_t;

endpackage : tpo_pkg

/* File: tpo_group.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_group
	import tpo_pkg::*;
#(
	parameter int GAP_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic trig_in,
	input wire logic nonovl_in,
	input wire logic [GAP_W-1:0] gap_in,
	input wire logic [3:0] cur_in,
	input wire logic [3:0] next_in,
	output logic load_out,
	output logic [3:0] data_out
);

	generate
		if (GAP_W < 1 || GAP_W > 16) begin : g_bad_gap
			$error("tpo_group: GAP_W must lie in 1..16");
		end
	endgenerate

	tpo_grp_state_t state;
	logic [GAP_W-1:0] count;
	logic [3:0] target;
	logic split;

	// Gap of zero degrades to a plain load, so no stuck state
	assign split = nonovl_in && (gap_in != '0);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= TPO_ST_IDLE;
			count <= '0;
			target <= 4'h0;
		end else if (trig_in) begin
			// A fresh trigger restarts any gap still running, or cancels it when split is off
			if (split) begin
				state <= TPO_ST_GAP; // R4
				count <= gap_in;
				target <= next_in;
			end else begin
				state <= TPO_ST_IDLE;
			end
		end else begin
			case (state)
				TPO_ST_IDLE: begin
					count <= count;
				end
				TPO_ST_GAP: begin
					if (count == GAP_W'(1)) begin
						state <= TPO_ST_IDLE;
					end else begin
						count <= count - GAP_W'(1);
					end
				end
				default: begin
					state <= TPO_ST_IDLE;
				end
			endcase
		end
	end

	// Falling bits go at once, rising bits wait out the gap
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			load_out <= 1'b0;
			data_out <= 4'h0;
		end else if (trig_in) begin
			load_out <= 1'b1; // R11
			data_out <= split ? (cur_in & next_in) : next_in; // R4
		end else if (state == TPO_ST_GAP && count == GAP_W'(1)) begin
			load_out <= 1'b1;
			data_out <= target; // R4
		end else begin
			load_out <= 1'b0;
		end
	end

endmodule : tpo_group
`default_nettype wire

/* File: tpo_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_top_props
	import tpo_pkg::*;
#(
	parameter int NUM_GROUPS = 4,
	parameter int GAP_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire tpo_apb_req_t apb_req_in,
	input wire tpo_apb_rsp_t apb_rsp_out,
	input wire logic [3:0] cmp_match_in,
	input wire logic [15:0] pattern_out_pins_out,
	input wire logic [15:0] pattern_oe_out,
	input wire logic [31:0] port_b_func_out,
	input wire logic [3:0] dma_req_out
);
	logic [8:0] since_match;
	logic wr_acc;
	assign wr_acc = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
	// Saturates so a long quiet spell never wraps back into the load window
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) since_match <= 9'h1ff;
		else if (cmp_match_in != 4'h0) since_match <= 9'h000;
		else if (since_match != 9'h1ff) since_match <= since_match + 9'h001;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_setup;
		apb_req_in.psel && !apb_req_in.penable;
	endsequence
	sequence s_access;
		apb_req_in.psel && apb_req_in.penable;
	endsequence
	a_ready_access: assert property (s_setup ##1 s_access |-> apb_rsp_out.pready)
		else $error("pready low in access cycle");
	a_idle_quiet: assert property (!apb_req_in.psel |-> !apb_rsp_out.pready && !apb_rsp_out.pslverr)
		else $error("response outside a transfer");
	a_reset_outputs: assert property ($rose(resetn_in) |->
		pattern_out_pins_out == 16'h0000 && pattern_oe_out == 16'h0000 && dma_req_out == 4'h0)
		else $error("outputs not cleared after reset");
	a_dma_cause: assert property (dma_req_out != 4'h0 |->
		(dma_req_out & ~$past(cmp_match_in)) == 4'h0)
		else $error("dma request without a match");
	a_oe_by_write: assert property ($changed(pattern_oe_out) |-> $past(wr_acc))
		else $error("enable changed without a write");
	a_func_by_write: assert property ($changed(port_b_func_out) |-> $past(wr_acc))
		else $error("function control changed without a write");
	a_plain_bits_hold: assert property (!$past(wr_acc) && $stable(pattern_oe_out) |->
		((pattern_out_pins_out ^ $past(pattern_out_pins_out)) & ~pattern_oe_out) == 16'h0000)
		else $error("non-pattern bit changed without a write");
	a_enabled_late: assert property (((pattern_out_pins_out ^ $past(pattern_out_pins_out))
		& pattern_oe_out & $past(pattern_oe_out)) != 16'h0000 |->
		since_match >= 9'h001 && since_match <= 9'h101)
		else $error("pattern bit changed outside a load window");
endmodule : tpo_top_props

bind tpo_top tpo_top_props #(.NUM_GROUPS(NUM_GROUPS), .GAP_W(GAP_W)) u_tpo_top_props (
	.clk_in(clk_in), .resetn_in(resetn_in), .apb_req_in(apb_req_in),
	.apb_rsp_out(apb_rsp_out), .cmp_match_in(cmp_match_in),
	.pattern_out_pins_out(pattern_out_pins_out), .pattern_oe_out(pattern_oe_out),
	.port_b_func_out(port_b_func_out), .dma_req_out(dma_req_out));
`default_nettype wire

/* File: tpo_loads.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_loads (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [15:0] pins_in,
	input wire logic [15:0] oe_in,
	output logic [3:0] overlap_out
);
	logic [15:0] prev;
	// A group rising and falling on one edge would glitch its loads
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev <= 16'h0000;
			overlap_out <= 4'h0;
		end else begin
			prev <= pins_in;
			for (int g = 0; g < 4; g++) begin
				if (|(pins_in[4*g +: 4] & ~prev[4*g +: 4] & oe_in[4*g +: 4])
					&& |(~pins_in[4*g +: 4] & prev[4*g +: 4] & oe_in[4*g +: 4])) begin
					overlap_out[g] <= 1'b1;
				end
			end
		end
	end
endmodule : tpo_loads
`default_nettype wire

/* File: tpo_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tpo_regs.svh"
module tpo_top_tb
	import tpo_pkg::*;
;
	logic clk_in = 1'b0;
	logic [3:0] strb = 4'hf;
	logic resetn = 1'b0;
	tpo_apb_req_t req = '0;
	tpo_apb_rsp_t rsp;
	logic [3:0] cmp = 4'h0;
	logic [15:0] pins, oe, exp_pins, gm;
	logic [31:0] func, rdata;
	logic [3:0] dma, ovl;
	logic rerr;
	int num_errors = 0;
	int samples_checked = 0;
	logic [27:0] r_idx [12] = '{`TPO_IDX_MODE, `TPO_IDX_TRIG_SEL, `TPO_IDX_NDEN_HIGH,
		`TPO_IDX_NDEN_LOW, `TPO_IDX_ND_HIGH, `TPO_IDX_ND_LOW, `TPO_IDX_ND_G0, `TPO_IDX_ND_G2,
		`TPO_IDX_PORT_DATA, `TPO_IDX_FUNC_HIGH, `TPO_IDX_FUNC_LOW, `TPO_IDX_GAP};
	logic [31:0] r_exp [12] = '{32'hf0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'hff,
		32'h0, 32'h0, 32'h0, 32'h0};
	always #50 clk_in = ~clk_in;
	tpo_top #(.NUM_GROUPS(4), .GAP_W(8)) u_tpo_top (.clk_in(clk_in), .resetn_in(resetn),
		.apb_req_in(req), .apb_rsp_out(rsp), .cmp_match_in(cmp), .pattern_out_pins_out(pins),
		.pattern_oe_out(oe), .port_b_func_out(func), .dma_req_out(dma));
	tpo_loads u_tpo_loads (.clk_in(clk_in), .resetn_in(resetn), .pins_in(pins), .oe_in(oe),
		.overlap_out(ovl));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic apb(input logic [27:0] idx, input logic wr_en, input logic [31:0] wd);
		@(posedge clk_in);
		req.psel <= 1'b1;
		req.pwrite <= wr_en;
		req.paddr <= {2'b00, idx, 2'b00};
		req.pwdata <= wd;
		req.pstrb <= strb;
		@(posedge clk_in);
		req.penable <= 1'b1;
		// The wait ends on pready; only the watchdog ends a wait that pready never answers
		do begin
			@(posedge clk_in);
		end while (rsp.pready !== 1'b1);
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Let the write land before anyone looks at the outputs
		@(negedge clk_in);
	endtask : apb
	task automatic wr(input logic [27:0] idx, input logic [31:0] d);
		apb(idx, 1'b1, d);
	endtask : wr
	task automatic rd_chk(input logic [27:0] idx, input logic [31:0] e);
		apb(idx, 1'b0, 32'h0);
		check(rdata, e);
	endtask : rd_chk
	task automatic pulse(input logic [3:0] m, input logic [3:0] dexp);
		@(posedge clk_in);
		cmp <= m;
		@(posedge clk_in);
		cmp <= 4'h0;
		@(negedge clk_in);
		check({28'h0, dma}, {28'h0, dexp});
		@(negedge clk_in);
	endtask : pulse
	task automatic do_reset;
		@(posedge clk_in);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_in);
		resetn <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd_chk(r_idx[i], r_exp[i]);
		end
		check({16'h0, pins}, 32'h0);
	endtask : do_reset
	initial begin
		do_reset();
		apb(28'h5fffff9, 1'b0, 32'h0);
		check({31'h0, rerr}, 32'h1);
		wr(`TPO_IDX_FUNC_HIGH, 32'ha5c3);
		wr(`TPO_IDX_FUNC_LOW, 32'h3c5a);
		check(func, 32'ha5c33c5a);
		strb = 4'h2;
		wr(`TPO_IDX_FUNC_LOW, 32'h1111);
		check(func, 32'ha5c3115a);
		strb = 4'hf;
		wr(`TPO_IDX_PORT_DATA, 32'h1234);
		check({16'h0, pins}, 32'h1234);
		wr(`TPO_IDX_NDEN_LOW, 32'h5a);
		wr(`TPO_IDX_NDEN_HIGH, 32'hf0);
		check({16'h0, oe}, 32'hf05a);
		wr(`TPO_IDX_PORT_DATA, 32'hffff);
		exp_pins = (16'h1234 & 16'hf05a) | (16'hffff & ~16'hf05a);
		check({16'h0, pins}, {16'h0, exp_pins});
		rd_chk(`TPO_IDX_PORT_DATA, {16'h0, exp_pins});
		wr(28'h5000ff1, 32'ha4);
		rd_chk(`TPO_IDX_TRIG_SEL, 32'ha4);
		wr(`TPO_IDX_ND_LOW, 32'h9c);
		rd_chk(`TPO_IDX_ND_LOW, 32'h9f);
		wr(`TPO_IDX_ND_G0, 32'h03);
		rd_chk(`TPO_IDX_ND_G0, 32'hf3);
		wr(`TPO_IDX_ND_HIGH, 32'h7e);
		rd_chk(`TPO_IDX_ND_HIGH, 32'h7e);
		rd_chk(`TPO_IDX_ND_G2, 32'hff);
		for (int c = 0; c < 4; c++) begin
			gm = {{8{c == 2}}, {4{c == 1}}, {4{c == 0}}} & 16'hf05a;
			pulse(4'(1 << c), (c < 3) ? 4'(1 << c) : 4'h0);
			exp_pins = (exp_pins & ~gm) | (16'h7e93 & gm);
			check({16'h0, pins}, {16'h0, exp_pins});
		end
		wr(`TPO_IDX_MODE, 32'h04);
		rd_chk(28'h5000ff0, 32'hf4);
		wr(`TPO_IDX_GAP, 32'h03);
		wr(`TPO_IDX_PORT_DATA, 32'h0600);
		exp_pins = (exp_pins & 16'hf05a) | (16'h0600 & ~16'hf05a);
		wr(`TPO_IDX_NDEN_HIGH, 32'hff);
		wr(`TPO_IDX_ND_HIGH, 32'h89);
		pulse(4'h4, 4'h4);
		check({16'h0, pins}, {16'h0, 4'h8, 4'h0, exp_pins[7:0]});
		repeat (3) @(negedge clk_in);
		check({16'h0, pins}, {16'h0, 4'h8, 4'h9, exp_pins[7:0]});
		check({28'h0, ovl}, 32'h8);
		do_reset();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		print_verdict();
	end
endmodule : tpo_top_tb
`default_nettype wire
